/* File: hsi_board_model.sv */
// Board-side model: strap resistors, external reset source and shared indicator pin
`timescale 1ns/100ps
`default_nettype none

module hsi_board_model (
  input  wire logic                ref_clk,
  input  wire hsi_pkg::hsi_strap_s strapSet,
  input  wire logic                indicatorOut,
  input  wire logic                indicatorOeN,
  output logic                     resetPinN,
  output logic                     configSelectHigh,
  output logic                     configSelectMid,
  output logic                     configSelectLow,
  output logic                     fixedPortStrapHi,
  output logic                     indicatorIn,
  output logic                     clockRateSelect
);
  assign configSelectHigh = strapSet.cfg[2];
  assign configSelectMid  = strapSet.cfg[1];
  assign configSelectLow  = strapSet.cfg[0];
  assign fixedPortStrapHi = strapSet.fixed[1];
  assign clockRateSelect  = strapSet.rate48;
  // Shared pin shows the strap resistor unless the device drives it
  assign indicatorIn = indicatorOeN ? strapSet.fixed[0] : indicatorOut;

  initial resetPinN = 1'b1;

  // Low pulse a few cycles longer than the minimum width
  task automatic pulse_reset();
    resetPinN <= 1'b0;
    repeat (hsi_pkg::RESET_HOLD_CYC + 5) @(posedge ref_clk);
    resetPinN <= 1'b1;
  endtask
endmodule // hsi_board_model

`default_nettype wire

/* File: hsi_pkg.sv */
// Shared constants and types for the hub strap sampling and indicator block
`default_nettype none

package hsi_pkg;

  // Reset timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_MIN_NS  = 1000;
  localparam int RESET_HOLD_CYC =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS   = 8'h04;
  localparam logic [7:0] LIVE_OFS   = 8'h08;

  // Status fields
  localparam int ST_CFG_LSB   = 0;
  localparam int ST_FIXED_LSB = 3;
  localparam int ST_SELFPWR   = 5;
  localparam int ST_RATE48    = 6;
  localparam int ST_STRAPEN   = 7;
  localparam int ST_METH_LSB  = 8;
  localparam int ST_MASK_LSB  = 12;
  localparam int ST_ACTLOW    = 15;

  // Control fields
  localparam int CTRL_IND_EN = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // Live fields
  localparam int LIVE_ACTIVE  = 0;
  localparam int LIVE_LEVEL   = 1;
  localparam int LIVE_INRESET = 2;

  // Fixed-port strap codes
  localparam logic [1:0] FIX_NONE = 2'h0;
  localparam logic [1:0] FIX_P1   = 2'h1;
  localparam logic [1:0] FIX_P12  = 2'h2;
  localparam logic [1:0] FIX_P123 = 2'h3;

  // Lower select codes
  localparam logic [1:0] SEL_SMBUS  = 2'h1;
  localparam logic [1:0] SEL_EEPROM = 2'h3;

  // Pin vector positions at the synchroniser
  localparam int PIN_RESET_N = 0;
  localparam int PIN_SUPPLY  = 1;
  localparam int PIN_CFG_LO  = 2;
  localparam int PIN_CFG_MID = 3;
  localparam int PIN_CFG_HI  = 4;
  localparam int PIN_FIX_HI  = 5;
  localparam int PIN_IND     = 6;
  localparam int PIN_RATE    = 7;
  localparam int PIN_EXTCLK  = 8;
  localparam int PIN_COUNT   = 9;

  typedef enum logic [3:0] {
    METH_DEF_STRAP = 4'b0001,
    METH_SMBUS     = 4'b0010,
    METH_EEPROM    = 4'b0100,
    METH_DEF_FIXED = 4'b1000
  } hsi_method_e;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b10
  } hsi_rst_e;

  typedef struct packed {
    logic [2:0] cfg;
    logic [1:0] fixed;
    logic       selfPow;
    logic       rate48;
  } hsi_strap_s;

  localparam hsi_strap_s STRAP_RESET = '0;

endpackage

`default_nettype wire

/* File: hsi_strap_ind.sv */
// Strap capture at reset release, configuration decode and activity indicator
`timescale 1ns/100ps
`default_nettype none

module hsi_strap_ind #(
  parameter int LARGE_PKG = 0,
  parameter int ADDR_W    = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              resetPinN,
  input  wire logic              supplyStable,
  input  wire logic              configSelectHigh,
  input  wire logic              configSelectMid,
  input  wire logic              configSelectLow,
  input  wire logic              fixedPortStrapHi,
  input  wire logic              indicatorIn,
  output logic                   indicatorOut,
  output logic                   indicatorOeN,
  input  wire logic              clockRateSelect,
  input  wire logic              externalClock,
  input  wire logic              hubConfigured,
  input  wire logic              hubSuspended,
  output logic                   coreReset,
  output hsi_pkg::hsi_strap_s    strapInfo,
  output logic      [3:1]        portFixedMask,
  output hsi_pkg::hsi_method_e   configMethod,
  output logic                   strapsEnabled,
  output logic                   selfPowered,
  output logic                   rate48Mode
);

  if (LARGE_PKG != 0 && LARGE_PKG != 1) begin : g_chk_pkg
    $error("hsi_strap_ind: LARGE_PKG must be 0 or 1");
  end
  if (ADDR_W < 8) begin : g_chk_addr
    $error("hsi_strap_ind: ADDR_W must be at least 8");
  end

  localparam logic LARGE = (LARGE_PKG != 0);
  localparam logic [4:0] HOLD_LAST = 5'(hsi_pkg::RESET_HOLD_CYC - 1);

  function automatic logic [3:1] fixedDecode(input logic [1:0] code);
    case (code)
      hsi_pkg::FIX_P1:   fixedDecode = 3'b001;
      hsi_pkg::FIX_P12:  fixedDecode = 3'b011;
      hsi_pkg::FIX_P123: fixedDecode = 3'b111;
      default:           fixedDecode = 3'b000;
    endcase
  endfunction

  function automatic hsi_pkg::hsi_method_e methodDecode(input logic [2:0] cfg);
    if (LARGE && cfg[2]) begin
      methodDecode = hsi_pkg::METH_DEF_FIXED;
    end else begin
      case (cfg[1:0])
        hsi_pkg::SEL_SMBUS:  methodDecode = hsi_pkg::METH_SMBUS;
        hsi_pkg::SEL_EEPROM: methodDecode = hsi_pkg::METH_EEPROM;
        default:             methodDecode = hsi_pkg::METH_DEF_STRAP;
      endcase
    end
  endfunction

  logic [hsi_pkg::PIN_COUNT-1:0] pinRaw;
  logic [hsi_pkg::PIN_COUNT-1:0] pinSync;

  assign pinRaw = {externalClock, clockRateSelect, indicatorIn,
                   fixedPortStrapHi, configSelectHigh, configSelectMid,
                   configSelectLow, supplyStable, resetPinN};

  hsi_sync #(
    .WIDTH (hsi_pkg::PIN_COUNT)
  ) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pinIn   (pinRaw),
    .pinOut  (pinSync)
  );

  // Reset sequencing
  hsi_pkg::hsi_rst_e rstState_r;
  logic [4:0]        holdCnt_r;
  logic              srcHold;
  logic              releasePulse;

  assign srcHold = !pinSync[hsi_pkg::PIN_RESET_N]
                || !pinSync[hsi_pkg::PIN_SUPPLY];
  assign releasePulse = (rstState_r == hsi_pkg::ST_HOLD) && !srcHold
                     && (holdCnt_r == HOLD_LAST);
  assign coreReset = (rstState_r != hsi_pkg::ST_RUN);

  // Internal reset is stretched to the least pulse width after every source lets go
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rstState_r <= hsi_pkg::ST_HOLD;
      holdCnt_r  <= '0;
    end else begin
      case (rstState_r)
        hsi_pkg::ST_HOLD: begin
          if (srcHold) begin
            holdCnt_r <= '0;
          end else if (holdCnt_r == HOLD_LAST) begin
            rstState_r <= hsi_pkg::ST_RUN;
          end else begin
            holdCnt_r <= holdCnt_r + 5'd1;
          end
        end
        hsi_pkg::ST_RUN: begin
          if (srcHold) begin
            rstState_r <= hsi_pkg::ST_HOLD;
            holdCnt_r  <= '0;
          end
        end
        default: begin
          rstState_r <= hsi_pkg::ST_HOLD;
          holdCnt_r  <= '0;
        end
      endcase
    end
  end

  // Strap capture
  logic [2:0]          cfgNow;
  hsi_pkg::hsi_method_e methNow;
  hsi_pkg::hsi_strap_s strap_nxt;

  assign cfgNow = {LARGE & pinSync[hsi_pkg::PIN_CFG_HI],
                   pinSync[hsi_pkg::PIN_CFG_MID],
                   pinSync[hsi_pkg::PIN_CFG_LO]};
  assign methNow = methodDecode(cfgNow);

  always_comb begin
    strap_nxt         = hsi_pkg::STRAP_RESET;
    strap_nxt.cfg     = cfgNow;
    strap_nxt.selfPow = pinSync[hsi_pkg::PIN_IND];
    if (methNow == hsi_pkg::METH_DEF_STRAP) begin
      strap_nxt.fixed = {pinSync[hsi_pkg::PIN_FIX_HI],
                         pinSync[hsi_pkg::PIN_IND]};
    end
    strap_nxt.rate48 = LARGE & pinSync[hsi_pkg::PIN_EXTCLK]
                     & pinSync[hsi_pkg::PIN_RATE];
  end

  // Only the release edge loads the straps
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strapInfo <= hsi_pkg::STRAP_RESET;
    end else if (releasePulse) begin
      strapInfo <= strap_nxt;
    end
  end

  logic activeLow;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      configMethod  <= hsi_pkg::METH_DEF_STRAP;
      strapsEnabled <= 1'b0;
      portFixedMask <= '0;
      activeLow     <= 1'b0;
    end else if (releasePulse) begin
      configMethod  <= methNow;
      strapsEnabled <= (methNow == hsi_pkg::METH_DEF_STRAP);
      portFixedMask <= fixedDecode(strap_nxt.fixed);
      activeLow     <= strap_nxt.fixed[0];
    end
  end

  assign selfPowered = strapInfo.selfPow;
  assign rate48Mode  = strapInfo.rate48;

  // Register file
  logic [31:0] ctrl_r;
  logic        accSetup;
  logic        accDone;
  logic        addrHit;
  logic        indActive;

  assign accSetup = psel && !penable;
  assign accDone  = psel && penable;
  assign addrHit  = (paddr[7:0] == hsi_pkg::STATUS_OFS)
                 || (paddr[7:0] == hsi_pkg::CTRL_OFS)
                 || (paddr[7:0] == hsi_pkg::LIVE_OFS);
  assign pready   = 1'b1;
  assign pslverr  = accDone && !addrHit;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_r <= hsi_pkg::CTRL_RESET;
    end else if (accDone && pwrite && pstrb[0]
                 && paddr[7:0] == hsi_pkg::CTRL_OFS) begin
      ctrl_r[hsi_pkg::CTRL_IND_EN] <= pwdata[hsi_pkg::CTRL_IND_EN];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata <= '0;
    end else if (accSetup) begin
      prdata <= '0;
      case (paddr[7:0])
        hsi_pkg::STATUS_OFS: begin
          prdata[hsi_pkg::ST_CFG_LSB +: 3]   <= strapInfo.cfg;
          prdata[hsi_pkg::ST_FIXED_LSB +: 2] <= strapInfo.fixed;
          prdata[hsi_pkg::ST_SELFPWR]        <= strapInfo.selfPow;
          prdata[hsi_pkg::ST_RATE48]         <= strapInfo.rate48;
          prdata[hsi_pkg::ST_STRAPEN]        <= strapsEnabled;
          prdata[hsi_pkg::ST_METH_LSB +: 4]  <= configMethod;
          prdata[hsi_pkg::ST_MASK_LSB +: 3]  <= portFixedMask;
          prdata[hsi_pkg::ST_ACTLOW]         <= activeLow;
        end
        hsi_pkg::CTRL_OFS: begin
          prdata <= ctrl_r;
        end
        hsi_pkg::LIVE_OFS: begin
          prdata[hsi_pkg::LIVE_ACTIVE]  <= indActive;
          prdata[hsi_pkg::LIVE_LEVEL]   <= indicatorOut;
          prdata[hsi_pkg::LIVE_INRESET] <= coreReset;
        end
        default: begin
          prdata <= '0;
        end
      endcase
    end
  end

  // Indicator pin; released during reset so its strap can be read
  assign indActive = hubConfigured && !hubSuspended
                  && ctrl_r[hsi_pkg::CTRL_IND_EN];

  always_ff @(posedge ref_clk) begin
    if (reset || coreReset) begin
      indicatorOut <= 1'b0;
      indicatorOeN <= 1'b1;
    end else begin
      indicatorOut <= indActive ^ activeLow;
      indicatorOeN <= 1'b0;
    end
  end

  // Checks
  high_strap_zero_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    !LARGE |-> !strapInfo.cfg[2] && !cfgNow[2])
    else $error("highest strap not zero in small package");

  strap_capture_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    releasePulse |=> strapInfo.cfg == $past(cfgNow) && !coreReset)
    else $error("config straps not captured at release");

  strap_hold_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    !releasePulse |=> $stable(strapInfo) && $stable(portFixedMask))
    else $error("latched straps changed outside release");

  reset_stretch_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    $fell(coreReset) |-> !$past(srcHold) && $past(holdCnt_r) == HOLD_LAST)
    else $error("internal reset released early");

  source_reset_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    srcHold |=> coreReset [*2])
    else $error("reset source did not hold logic in reset");

  fixed_decode_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    !coreReset |-> portFixedMask == fixedDecode(strapInfo.fixed))
    else $error("fixed port mask does not match strap");

  led_polarity_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    !coreReset |-> activeLow == strapInfo.fixed[0])
    else $error("indicator polarity does not match strap");

  led_level_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    !coreReset ##1 !coreReset |->
      !indicatorOeN && indicatorOut == ($past(indActive) ^ activeLow))
    else $error("indicator level wrong");

  smbus_mode_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    releasePulse && !LARGE && cfgNow[1:0] == hsi_pkg::SEL_SMBUS
      |=> configMethod == hsi_pkg::METH_SMBUS && !strapsEnabled
          && portFixedMask == 3'b000)
    else $error("SMBus straps not decoded");

  rate_select_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    releasePulse |=> rate48Mode == (LARGE && $past(pinSync[hsi_pkg::PIN_RATE])
                                    && $past(pinSync[hsi_pkg::PIN_EXTCLK])))
    else $error("clock rate select wrong");

  default_strap_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    releasePulse && !cfgNow[2] && !cfgNow[0]
      |=> configMethod == hsi_pkg::METH_DEF_STRAP && strapsEnabled)
    else $error("default strap method not selected");

  fixed_capture_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    releasePulse && methNow == hsi_pkg::METH_DEF_STRAP
      |=> strapInfo.fixed == {$past(pinSync[hsi_pkg::PIN_FIX_HI]),
                              $past(pinSync[hsi_pkg::PIN_IND])})
    else $error("fixed port straps not captured");

  fixed_off_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    releasePulse && methNow != hsi_pkg::METH_DEF_STRAP
      |=> strapInfo.fixed == hsi_pkg::FIX_NONE && portFixedMask == '0 && !activeLow)
    else $error("fixed port straps used while disabled");

  self_power_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    releasePulse |=> selfPowered == $past(pinSync[hsi_pkg::PIN_IND]))
    else $error("self power sense not captured");

  led_idle_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    !coreReset && (!hubConfigured || hubSuspended) ##1 !coreReset
      |-> indicatorOut == activeLow)
    else $error("indicator asserted while idle");

endmodule // hsi_strap_ind

`default_nettype wire

/* File: hsi_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module hsi_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;

  if (WIDTH < 1) begin : g_chk
    $error("hsi_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // Per bit, the output follows only when the last two stages agree
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pinOut <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_r[i] == stage3_r[i]) begin
          pinOut[i] <= stage3_r[i];
        end
      end
    end
  end

endmodule // hsi_sync

`default_nettype wire

/* File: hsi_tb.sv */
// Self-checking testbench for the strap sampling and indicator block
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic                 ref_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata;
  logic                 supplyStable, hubConfigured, hubSuspended, coreReset;
  logic                 indicatorOut, indicatorOeN, resetPinN, indicatorIn;
  logic                 cfgHi, cfgMid, cfgLo, fixHi, rateSel, extClk, lgRate48;
  logic                 strapsEnabled, selfPowered, rate48Mode;
  logic [3:1]           portFixedMask, lgMask;
  hsi_pkg::hsi_strap_s  strapInfo, straps, lgStrap;
  hsi_pkg::hsi_method_e configMethod, lgMethod;
  int                   mismatches, numChecks, cycles;

  hsi_strap_ind #(.LARGE_PKG(0), .ADDR_W(8)) u_hsi_strap_ind (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .resetPinN(resetPinN),
    .supplyStable(supplyStable), .configSelectHigh(cfgHi),
    .configSelectMid(cfgMid), .configSelectLow(cfgLo), .fixedPortStrapHi(fixHi),
    .indicatorIn(indicatorIn), .indicatorOut(indicatorOut),
    .indicatorOeN(indicatorOeN), .clockRateSelect(rateSel), .externalClock(extClk),
    .hubConfigured(hubConfigured), .hubSuspended(hubSuspended),
    .coreReset(coreReset), .strapInfo(strapInfo), .portFixedMask(portFixedMask),
    .configMethod(configMethod), .strapsEnabled(strapsEnabled),
    .selfPowered(selfPowered), .rate48Mode(rate48Mode));

  // Larger package variant on the same pins; only its latched straps are judged
  hsi_strap_ind #(.LARGE_PKG(1), .ADDR_W(8)) u_hsi_strap_ind_lg (
    .ref_clk(ref_clk), .reset(reset), .psel(1'b0), .penable(1'b0), .pwrite(1'b0),
    .paddr(8'h00), .pwdata(32'h0000_0000), .pstrb(4'h0), .prdata(), .pready(),
    .pslverr(), .resetPinN(resetPinN), .supplyStable(supplyStable),
    .configSelectHigh(cfgHi), .configSelectMid(cfgMid), .configSelectLow(cfgLo),
    .fixedPortStrapHi(fixHi), .indicatorIn(indicatorIn), .indicatorOut(),
    .indicatorOeN(), .clockRateSelect(rateSel), .externalClock(extClk),
    .hubConfigured(hubConfigured), .hubSuspended(hubSuspended), .coreReset(),
    .strapInfo(lgStrap), .portFixedMask(lgMask), .configMethod(lgMethod),
    .strapsEnabled(), .selfPowered(), .rate48Mode(lgRate48));

  hsi_board_model u_hsi_board_model (
    .ref_clk(ref_clk), .strapSet(straps), .indicatorOut(indicatorOut),
    .indicatorOeN(indicatorOeN), .resetPinN(resetPinN), .configSelectHigh(cfgHi),
    .configSelectMid(cfgMid), .configSelectLow(cfgLo), .fixedPortStrapHi(fixHi),
    .indicatorIn(indicatorIn), .clockRateSelect(rateSel));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // One APB transfer; an idle cycle first keeps transfers apart
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    penable <= 1'b0;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_rel();
    int n;
    n = 0;
    while (coreReset !== 1'b0 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 100) mismatches++;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic reset_test();
    logic [31:0] rd;
    logic        err;
    @(posedge ref_clk);
    chk(32'(coreReset), 32'h0000_0001);
    chk(32'(indicatorOeN), 32'h0000_0001);
    apb(1'b0, hsi_pkg::CTRL_OFS, 32'h0000_0000, rd, err);
    chk(rd, hsi_pkg::CTRL_RESET);
    wait_rel();
    $display("reset test done");
  endtask

  task automatic capture(input logic [1:0] lo, input logic [1:0] fx);
    logic [3:0]  m;
    logic [1:0]  fe;
    logic [2:0]  mk;
    logic        se, err;
    logic [31:0] st, rd;
    logic [3:0]  lm;
    logic [2:0]  lk;
    m = (lo == hsi_pkg::SEL_SMBUS) ? hsi_pkg::METH_SMBUS :
        (lo == hsi_pkg::SEL_EEPROM) ? hsi_pkg::METH_EEPROM : hsi_pkg::METH_DEF_STRAP;
    se = (m == hsi_pkg::METH_DEF_STRAP);
    fe = se ? fx : 2'h0;
    mk = 3'((4'h1 << fe) - 4'h1);
    // Larger package: high strap set means default setup with straps off
    lm = fx[0] ? 4'(hsi_pkg::METH_DEF_FIXED) : m;
    lk = fx[0] ? 3'h0 : mk;
    straps <= '{cfg: {fx[0], lo}, fixed: fx, selfPow: 1'b0, rate48: fx[1]};
    extClk <= lo[1];
    @(posedge ref_clk);
    u_hsi_board_model.pulse_reset();
    wait_rel();
    chk(32'(strapInfo.cfg), {29'h0, 1'b0, lo});
    chk(32'(portFixedMask), 32'(mk));
    chk(32'(configMethod), 32'(m));
    chk(32'(strapsEnabled), 32'(se));
    chk(32'(selfPowered), 32'(fx[0]));
    chk(32'(rate48Mode), 32'h0000_0000);
    chk(32'(lgStrap.cfg), {29'h0, fx[0], lo});
    chk(32'(lgMethod), 32'(lm));
    chk(32'(lgMask), 32'(lk));
    chk(32'(lgRate48), 32'(fx[1] & lo[1]));
    apb(1'b0, hsi_pkg::STATUS_OFS, 32'h0000_0000, st, err);
    chk(st, {16'h0000, fe[0], mk, m, se, 1'b0, fx[0], fe, 1'b0, lo});
    hubConfigured <= 1'b1;
    hubSuspended  <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(32'(indicatorOeN), 32'h0000_0000);
    chk(32'(indicatorOut), 32'(!fe[0]));
    hubSuspended <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(32'(indicatorOut), 32'(fe[0]));
    hubConfigured <= 1'b0;
    hubSuspended  <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(32'(indicatorOut), 32'(fe[0]));
    // Pins move after release; latched values must not follow
    straps <= ~straps;
    repeat (8) @(posedge ref_clk);
    chk(32'(portFixedMask), 32'(mk));
    chk(32'(strapInfo.cfg), {29'h0, 1'b0, lo});
    chk(32'(lgStrap.cfg), {29'h0, fx[0], lo});
    apb(1'b0, hsi_pkg::STATUS_OFS, 32'h0000_0000, rd, err);
    chk(rd, st);
    $display("capture %0d/%0d done", lo, fx);
  endtask

  // Runs after a capture with fixed strap 01, so the indicator is active low
  task automatic apb_test();
    logic [31:0] st, rd;
    logic        err;
    hubConfigured <= 1'b1;
    apb(1'b0, hsi_pkg::LIVE_OFS, 32'h0000_0000, rd, err);
    chk(rd, 32'h0000_0001);
    apb(1'b0, hsi_pkg::STATUS_OFS, 32'h0000_0000, st, err);
    apb(1'b1, hsi_pkg::CTRL_OFS, 32'h0000_0000, rd, err);
    repeat (3) @(posedge ref_clk);
    chk(32'(indicatorOut), 32'h0000_0001);
    apb(1'b0, hsi_pkg::CTRL_OFS, 32'h0000_0000, rd, err);
    chk(rd, 32'h0000_0000);
    apb(1'b1, hsi_pkg::STATUS_OFS, 32'hFFFF_FFFF, rd, err);
    apb(1'b0, hsi_pkg::STATUS_OFS, 32'h0000_0000, rd, err);
    chk(rd, st);
    apb(1'b0, 8'h0C, 32'h0000_0000, rd, err);
    chk({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, hsi_pkg::CTRL_OFS, 32'h0000_0001, rd, err);
    hubConfigured <= 1'b0;
    $display("apb test done");
  endtask

  task automatic supply_test();
    supplyStable <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(32'(coreReset), 32'h0000_0001);
    chk(32'(indicatorOeN), 32'h0000_0001);
    supplyStable <= 1'b1;
    wait_rel();
    chk(32'(coreReset), 32'h0000_0000);
    $display("supply test done");
  endtask

  initial begin
    mismatches = 0;
    numChecks = 0;
    cycles = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    supplyStable = 1'b1;
    extClk = 1'b0;
    hubConfigured = 1'b0;
    hubSuspended = 1'b0;
    straps = hsi_pkg::STRAP_RESET;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    reset_test();
    for (int lo = 0; lo < 4; lo++) begin
      for (int fx = 0; fx < 4; fx++) begin
        capture(2'(lo), 2'(fx));
      end
    end
    capture(2'h0, 2'h1);
    apb_test();
    supply_test();
    tally_and_finish();
  end
endmodule // testbench

`default_nettype wire
